// ===== rtl/scaler_csc_geometry_consts.svh
`ifndef SCALER_CSC_GEOMETRY_CONSTS_SVH
`define SCALER_CSC_GEOMETRY_CONSTS_SVH

// Byte offsets of the register words
`define OFF_ROW0_CONST      12'h07C
`define OFF_ROW1_COEFF0     12'h080
`define OFF_ROW1_COEFF1     12'h084
`define OFF_ROW1_COEFF2     12'h088
`define OFF_ROW1_CONST      12'h08C
`define OFF_ROW2_COEFF0     12'h090
`define OFF_ROW2_COEFF1     12'h094
`define OFF_ROW2_COEFF2     12'h098
`define OFF_ROW2_CONST      12'h09C
`define OFF_STRIDE_EN       12'h0D0
`define OFF_STRIDE_VAL      12'h0D4
`define OFF_SCAN_CTRL       12'h0D8
`define OFF_STATUS          12'h0DC
`define OFF_IN_SIZE         12'h100
`define OFF_OUT_SIZE        12'h104
`define OFF_H_RATIO         12'h108
`define OFF_V_RATIO         12'h10C
`define OFF_H_PHASE         12'h110
`define OFF_V_PHASE_TOP     12'h114
`define OFF_V_PHASE_BOT     12'h118

// Storage slots
`define NUM_REGS            19
`define IDX_ROW0_CONST      5'h00
`define IDX_ROW1_COEFF0     5'h01
`define IDX_ROW1_CONST      5'h04
`define IDX_ROW2_COEFF0     5'h05
`define IDX_ROW2_CONST      5'h08
`define IDX_STRIDE_EN       5'h09
`define IDX_STRIDE_VAL      5'h0A
`define IDX_IN_SIZE         5'h0B
`define IDX_OUT_SIZE        5'h0C
`define IDX_H_RATIO         5'h0D
`define IDX_V_RATIO         5'h0E
`define IDX_H_PHASE         5'h0F
`define IDX_V_PHASE_TOP     5'h10
`define IDX_V_PHASE_BOT     5'h11
`define IDX_SCAN_CTRL       5'h12
`define IDX_STATUS          5'h13
`define IDX_MISS            5'h1F

// Writable bits per register kind
`define MASK_COEFF          32'h0000_1FFF
`define MASK_CONST          32'h0000_3FFF
`define MASK_BIT0           32'h0000_0001
`define MASK_SIZE           32'h1FFF_1FFF
`define MASK_RATIO          32'h00FF_FFFF
`define MASK_PHASE          32'h000F_FFFF
`define RESET_VALUE         32'h0000_0000

// Field positions
`define POS_HEIGHT          16
`define POS_STEP_INT        16

// AXI responses
`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2

`endif

// ===== rtl/scaler_csc_geometry_pkg.sv
`include "scaler_csc_geometry_consts.svh"

package scaler_csc_geometry_pkg;

    typedef struct packed {
        logic        awvalid;
        logic [11:0] awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [11:0] araddr;
        logic        rready;
    } axil_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } axil_rsp_t;

    // Settings handed to the pixel pipeline, dimensions already as real counts
    typedef struct packed {
        logic [1:0][2:0][12:0] matrix_coeff;
        logic [2:0][13:0]      matrix_offset_term;
        logic                  stride_active;
        logic                  line_pitch_value;
        logic [13:0]           in_width;
        logic [13:0]           in_height;
        logic [13:0]           out_width;
        logic [13:0]           out_height;
        logic [7:0]            h_step_integer_part;
        logic [15:0]           h_step_fraction_part;
        logic [7:0]            v_step_integer_part;
        logic [15:0]           v_step_fraction_part;
        logic [19:0]           h_start_phase;
        logic [19:0]           v_start_phase;
    } pipe_cfg_t;

    typedef enum logic [1:0] {WR_COLLECT = 2'b01, WR_RESP = 2'b10} wr_state_t;
    typedef enum logic [1:0] {RD_IDLE = 2'b01, RD_RESP = 2'b10} rd_state_t;

    typedef struct packed {
        wr_state_t                     wr_state;
        logic                          aw_seen;
        logic                          w_seen;
        logic [11:0]                   awaddr;
        logic [31:0]                   wdata;
        logic [3:0]                    wstrb;
        logic [1:0]                    bresp;
        rd_state_t                     rd_state;
        logic [31:0]                   rdata;
        logic [1:0]                    rresp;
        logic                          field;
        logic [`NUM_REGS-1:0][31:0]    regs;
        pipe_cfg_t                     pipe;
    } state_t;

endpackage

// ===== rtl/scaler_csc_geometry_regs.sv
// Functional notes
// - Each matrix row: three 13-bit coefficients times 2^10, 14-bit constant times 2^4; here row 0 has only its constant, no coefficients.
// - Line stride is applied only while enable bit 0 is 1; 0 disables it.
// - Stride value is the memory distance between consecutive written-back lines.
// - Input height 28:16 and width 12:0 hold the dimension minus one.
// - Output height 28:16 and width 12:0 hold the dimension minus one.
// - Horizontal step: integer part bits 23:16, fraction bits 15:0.
// - Vertical step: integer part bits 23:16, fraction bits 15:0.
// - Horizontal start phase is a 20-bit two's-complement value times 2^16.
// - Top field starts vertical interpolation from the first vertical phase.
// - Bottom field starts vertical interpolation from the second vertical phase.
// - All fields except the read-only status bits are read/write and reset to zero.
// - With interlaced output on, the display field picks top or bottom phase.
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
`include "scaler_csc_geometry_consts.svh"

module scaler_csc_geometry_regs (
    // Clock and reset
    input  wire logic                              clk_i,
    input  wire logic                              nrst_i,
    // Register bus
    input  wire scaler_csc_geometry_pkg::axil_req_t axi_i,
    output var  scaler_csc_geometry_pkg::axil_rsp_t axi_o,
    // Display timing
    input  wire logic                              display_field_i,
    // Pixel pipeline settings
    output var  scaler_csc_geometry_pkg::pipe_cfg_t cfg_o
);
    import scaler_csc_geometry_pkg::*;

    function automatic logic [4:0] reg_index(input logic [11:0] addr);
        case (addr)
            `OFF_ROW0_CONST:  reg_index = `IDX_ROW0_CONST;
            `OFF_ROW1_COEFF0: reg_index = 5'h01;
            `OFF_ROW1_COEFF1: reg_index = 5'h02;
            `OFF_ROW1_COEFF2: reg_index = 5'h03;
            `OFF_ROW1_CONST:  reg_index = `IDX_ROW1_CONST;
            `OFF_ROW2_COEFF0: reg_index = 5'h05;
            `OFF_ROW2_COEFF1: reg_index = 5'h06;
            `OFF_ROW2_COEFF2: reg_index = 5'h07;
            `OFF_ROW2_CONST:  reg_index = `IDX_ROW2_CONST;
            `OFF_STRIDE_EN:   reg_index = `IDX_STRIDE_EN;
            `OFF_STRIDE_VAL:  reg_index = `IDX_STRIDE_VAL;
            `OFF_IN_SIZE:     reg_index = `IDX_IN_SIZE;
            `OFF_OUT_SIZE:    reg_index = `IDX_OUT_SIZE;
            `OFF_H_RATIO:     reg_index = `IDX_H_RATIO;
            `OFF_V_RATIO:     reg_index = `IDX_V_RATIO;
            `OFF_H_PHASE:     reg_index = `IDX_H_PHASE;
            `OFF_V_PHASE_TOP: reg_index = `IDX_V_PHASE_TOP;
            `OFF_V_PHASE_BOT: reg_index = `IDX_V_PHASE_BOT;
            `OFF_SCAN_CTRL:   reg_index = `IDX_SCAN_CTRL;
            `OFF_STATUS:      reg_index = `IDX_STATUS;
            default:          reg_index = `IDX_MISS;
        endcase
    endfunction

    // Writable bits of each slot; everything else stays zero
    function automatic logic [31:0] reg_mask(input logic [4:0] idx);
        case (idx)
            `IDX_ROW0_CONST,
            `IDX_ROW1_CONST,
            `IDX_ROW2_CONST:  reg_mask = `MASK_CONST;
            5'h01, 5'h02, 5'h03,
            5'h05, 5'h06, 5'h07: reg_mask = `MASK_COEFF;
            `IDX_STRIDE_EN,
            `IDX_STRIDE_VAL,
            `IDX_SCAN_CTRL:   reg_mask = `MASK_BIT0;
            `IDX_IN_SIZE,
            `IDX_OUT_SIZE:    reg_mask = `MASK_SIZE;
            `IDX_H_RATIO,
            `IDX_V_RATIO:     reg_mask = `MASK_RATIO;
            `IDX_H_PHASE,
            `IDX_V_PHASE_TOP,
            `IDX_V_PHASE_BOT: reg_mask = `MASK_PHASE;
            default:          reg_mask = 32'h0000_0000;
        endcase
    endfunction

    state_t      q;
    state_t      d;
    logic        aw_hs;
    logic        w_hs;
    logic        wr_go;
    logic [11:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0]  wr_strb;
    logic [31:0] lane_mask;
    logic [4:0]  wr_idx;
    logic [4:0]  rd_idx;
    logic        use_bottom;

    assign axi_o.awready = (q.wr_state == WR_COLLECT) && !q.aw_seen;
    assign axi_o.wready  = (q.wr_state == WR_COLLECT) && !q.w_seen;
    assign axi_o.bvalid  = (q.wr_state == WR_RESP);
    assign axi_o.bresp   = q.bresp;
    assign axi_o.arready = (q.rd_state == RD_IDLE);
    assign axi_o.rvalid  = (q.rd_state == RD_RESP);
    assign axi_o.rdata   = q.rdata;
    assign axi_o.rresp   = q.rresp;
    assign cfg_o         = q.pipe;

    assign use_bottom = q.regs[`IDX_SCAN_CTRL][0] && display_field_i;

    always_comb
    begin
        d         = q;
        aw_hs     = axi_i.awvalid && axi_o.awready;
        w_hs      = axi_i.wvalid && axi_o.wready;
        wr_addr   = aw_hs ? axi_i.awaddr : q.awaddr;
        wr_data   = w_hs ? axi_i.wdata : q.wdata;
        wr_strb   = w_hs ? axi_i.wstrb : q.wstrb;
        wr_go     = (q.aw_seen || aw_hs) && (q.w_seen || w_hs);
        wr_idx    = reg_index(wr_addr);
        rd_idx    = reg_index(axi_i.araddr);
        lane_mask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};

        // Write channel: address and data accepted in either order
        case (q.wr_state)
            WR_COLLECT:
            begin
                if (aw_hs)
                begin
                    d.aw_seen = 1'b1;
                    d.awaddr  = axi_i.awaddr;
                end
                if (w_hs)
                begin
                    d.w_seen = 1'b1;
                    d.wdata  = axi_i.wdata;
                    d.wstrb  = axi_i.wstrb;
                end
                if (wr_go)
                begin
                    d.wr_state = WR_RESP;
                    d.bresp    = (wr_idx == `IDX_MISS) ? `RESP_SLVERR : `RESP_OKAY;
                    for (int i = 0; i < `NUM_REGS; i++)
                    begin
                        if (wr_idx == 5'(i))
                        begin
                            d.regs[i] = ((q.regs[i] & ~lane_mask) | (wr_data & lane_mask))
                                        & reg_mask(5'(i));
                        end
                    end
                end
            end
            WR_RESP:
            begin
                if (axi_i.bready)
                begin
                    d.wr_state = WR_COLLECT;
                    d.aw_seen  = 1'b0;
                    d.w_seen   = 1'b0;
                end
            end
            default:
            begin
                d.wr_state = WR_COLLECT;
            end
        endcase

        // Read channel
        case (q.rd_state)
            RD_IDLE:
            begin
                if (axi_i.arvalid)
                begin
                    d.rd_state = RD_RESP;
                    d.rresp    = `RESP_OKAY;
                    d.rdata    = 32'h0000_0000;
                    if (rd_idx == `IDX_STATUS)
                    begin
                        d.rdata = {30'h0000_0000, use_bottom, q.field};
                    end
                    else if (rd_idx == `IDX_MISS)
                    begin
                        d.rresp = `RESP_SLVERR;
                    end
                    else
                    begin
                        d.rdata = q.regs[rd_idx];
                    end
                end
            end
            RD_RESP:
            begin
                if (axi_i.rready)
                begin
                    d.rd_state = RD_IDLE;
                end
            end
            default:
            begin
                d.rd_state = RD_IDLE;
            end
        endcase

        d.field = display_field_i;

        // Settings for the pipeline, one cycle behind the register words
        for (int k = 0; k < 3; k++)
        begin
            d.pipe.matrix_coeff[0][k] = q.regs[`IDX_ROW1_COEFF0 + 5'(k)][12:0];
            d.pipe.matrix_coeff[1][k] = q.regs[`IDX_ROW2_COEFF0 + 5'(k)][12:0];
        end
        d.pipe.matrix_offset_term[0] = q.regs[`IDX_ROW0_CONST][13:0];
        d.pipe.matrix_offset_term[1] = q.regs[`IDX_ROW1_CONST][13:0];
        d.pipe.matrix_offset_term[2] = q.regs[`IDX_ROW2_CONST][13:0];
        d.pipe.stride_active    = q.regs[`IDX_STRIDE_EN][0];
        d.pipe.line_pitch_value = q.regs[`IDX_STRIDE_EN][0]
                                  & q.regs[`IDX_STRIDE_VAL][0];
        d.pipe.in_width   = {1'b0, q.regs[`IDX_IN_SIZE][12:0]} + 14'h0001;
        d.pipe.in_height  = {1'b0, q.regs[`IDX_IN_SIZE][`POS_HEIGHT +: 13]} + 14'h0001;
        d.pipe.out_width  = {1'b0, q.regs[`IDX_OUT_SIZE][12:0]} + 14'h0001;
        d.pipe.out_height = {1'b0, q.regs[`IDX_OUT_SIZE][`POS_HEIGHT +: 13]} + 14'h0001;
        d.pipe.h_step_integer_part  = q.regs[`IDX_H_RATIO][`POS_STEP_INT +: 8];
        d.pipe.h_step_fraction_part = q.regs[`IDX_H_RATIO][15:0];
        d.pipe.v_step_integer_part  = q.regs[`IDX_V_RATIO][`POS_STEP_INT +: 8];
        d.pipe.v_step_fraction_part = q.regs[`IDX_V_RATIO][15:0];
        d.pipe.h_start_phase = q.regs[`IDX_H_PHASE][19:0];
        d.pipe.v_start_phase = use_bottom ? q.regs[`IDX_V_PHASE_BOT][19:0]
                                          : q.regs[`IDX_V_PHASE_TOP][19:0];
    end

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            q          <= '0;
            q.wr_state <= WR_COLLECT;
            q.rd_state <= RD_IDLE;
        end
        else
        begin
            q <= d;
        end
    end

    sequence write_taken;
        axi_o.awready && axi_i.awvalid && axi_o.wready && axi_i.wvalid;
    endsequence

    sequence bottom_selected;
        q.regs[`IDX_SCAN_CTRL][0] && display_field_i;
    endsequence

    AST_RESET_ZERO: assert property (@(posedge clk_i) disable iff (!nrst_i)
        $rose(nrst_i) |-> (q.regs == '0) && (cfg_o.in_width == 14'h0000))
        else $error("registers not zero after reset");

    AST_RESERVED_ZERO: assert property (@(posedge clk_i) disable iff (!nrst_i)
        ((q.regs[`IDX_IN_SIZE] & ~`MASK_SIZE) == 32'h0)
        && ((q.regs[`IDX_H_PHASE] & ~`MASK_PHASE) == 32'h0))
        else $error("reserved bits hold a one");

    AST_WRITE_RESP: assert property (@(posedge clk_i) disable iff (!nrst_i)
        write_taken |=> axi_o.bvalid && !axi_o.awready && !axi_o.wready)
        else $error("write response missing after both channels taken");

    AST_COEFF_FOLLOW: assert property (@(posedge clk_i) disable iff (!nrst_i)
        1'b1 |=> cfg_o.matrix_coeff[1][2] == $past(q.regs[5'h07][12:0])
                 && cfg_o.matrix_offset_term[0] == $past(q.regs[`IDX_ROW0_CONST][13:0]))
        else $error("matrix settings not taken from registers");

    AST_STRIDE_GATED: assert property (@(posedge clk_i) disable iff (!nrst_i)
        !q.regs[`IDX_STRIDE_EN][0] |=> !cfg_o.line_pitch_value && !cfg_o.stride_active)
        else $error("stride used while disabled");

    AST_STRIDE_VALUE: assert property (@(posedge clk_i) disable iff (!nrst_i)
        q.regs[`IDX_STRIDE_EN][0] |=> cfg_o.line_pitch_value == $past(q.regs[`IDX_STRIDE_VAL][0]))
        else $error("stride value not passed while enabled");

    AST_IN_SIZE: assert property (@(posedge clk_i) disable iff (!nrst_i)
        1'b1 |=> cfg_o.in_width == $past({1'b0, q.regs[`IDX_IN_SIZE][12:0]}) + 14'h0001
                 && cfg_o.in_height == $past({1'b0, q.regs[`IDX_IN_SIZE][28:16]}) + 14'h0001)
        else $error("input size not stored value plus one");

    AST_OUT_SIZE: assert property (@(posedge clk_i) disable iff (!nrst_i)
        1'b1 |=> cfg_o.out_height == $past({1'b0, q.regs[`IDX_OUT_SIZE][28:16]}) + 14'h0001)
        else $error("output size not stored value plus one");

    AST_STEP_SPLIT: assert property (@(posedge clk_i) disable iff (!nrst_i)
        1'b1 |=> {cfg_o.v_step_integer_part, cfg_o.v_step_fraction_part}
                 == $past(q.regs[`IDX_V_RATIO][23:0])
                 && cfg_o.h_step_integer_part == $past(q.regs[`IDX_H_RATIO][23:16]))
        else $error("step fields misplaced");

    AST_BOTTOM_PHASE: assert property (@(posedge clk_i) disable iff (!nrst_i)
        bottom_selected |=> cfg_o.v_start_phase == $past(q.regs[`IDX_V_PHASE_BOT][19:0]))
        else $error("bottom field phase not selected");

    AST_TOP_PHASE: assert property (@(posedge clk_i) disable iff (!nrst_i)
        !display_field_i |=> cfg_o.v_start_phase == $past(q.regs[`IDX_V_PHASE_TOP][19:0])
                             && cfg_o.h_start_phase == $past(q.regs[`IDX_H_PHASE][19:0]))
        else $error("top field or horizontal phase wrong");

endmodule
`default_nettype wire

// ===== testbench/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "scaler_csc_geometry_consts.svh"
`define CHK(a, e) \
    begin \
        checks_done++; \
        if ((a) !== (e)) \
        begin \
            failures++; \
            $display("Error at %0t: got %0h expected %0h", $time, (a), (e)); \
        end \
    end

module tb_top;
    import scaler_csc_geometry_pkg::*;

    logic        clk_i;
    logic        nrst_i;
    axil_req_t   req;
    axil_rsp_t   rsp;
    logic        field;
    logic        scan;
    pipe_cfg_t   cfg;
    int          failures;
    int          checks_done;
    logic [33:0] er;
    logic [1:0]  eb;
    logic [33:0] rq[$];
    logic [1:0]  bq[$];
    logic [31:0] sh [18];
    logic [11:0] offs [18] = '{`OFF_ROW0_CONST, `OFF_ROW1_COEFF0, `OFF_ROW1_COEFF1,
        `OFF_ROW1_COEFF2, `OFF_ROW1_CONST, `OFF_ROW2_COEFF0, `OFF_ROW2_COEFF1,
        `OFF_ROW2_COEFF2, `OFF_ROW2_CONST, `OFF_STRIDE_EN, `OFF_STRIDE_VAL, `OFF_IN_SIZE,
        `OFF_OUT_SIZE, `OFF_H_RATIO, `OFF_V_RATIO, `OFF_H_PHASE, `OFF_V_PHASE_TOP,
        `OFF_V_PHASE_BOT};
    logic [31:0] masks [18] = '{`MASK_CONST, `MASK_COEFF, `MASK_COEFF, `MASK_COEFF,
        `MASK_CONST, `MASK_COEFF, `MASK_COEFF, `MASK_COEFF, `MASK_CONST, `MASK_BIT0,
        `MASK_BIT0, `MASK_SIZE, `MASK_SIZE, `MASK_RATIO, `MASK_RATIO, `MASK_PHASE,
        `MASK_PHASE, `MASK_PHASE};

    scaler_csc_geometry_regs scaler_csc_geometry_regs_inst (
        .clk_i           (clk_i),
        .nrst_i          (nrst_i),
        .axi_i           (req),
        .axi_o           (rsp),
        .display_field_i (field),
        .cfg_o           (cfg)
    );

    initial clk_i = 1'b0;
    always #4 clk_i = ~clk_i;

    // Bus answers are matched against the oldest expectation
    always @(posedge clk_i)
    begin
        if (rsp.rvalid === 1'b1 && req.rready === 1'b1)
        begin
            er = rq.pop_front();
            `CHK(rsp.rdata, er[31:0])
            `CHK(rsp.rresp, er[33:32])
        end
        if (rsp.bvalid === 1'b1 && req.bready === 1'b1)
        begin
            eb = bq.pop_front();
            `CHK(rsp.bresp, eb)
        end
    end

    task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                       input logic [1:0] e);
        bit ad;
        bit wd;
        ad = 1'b0;
        wd = 1'b0;
        bq.push_back(e);
        req.awvalid <= 1'b1;
        req.awaddr  <= a;
        req.wvalid  <= 1'b1;
        req.wdata   <= d;
        req.wstrb   <= s;
        req.bready  <= 1'b1;
        while (!(ad && wd))
        begin
            @(posedge clk_i);
            if (!ad && rsp.awready === 1'b1)
            begin
                ad = 1'b1;
                req.awvalid <= 1'b0;
            end
            if (!wd && rsp.wready === 1'b1)
            begin
                wd = 1'b1;
                req.wvalid <= 1'b0;
            end
        end
        // Response ready stays high between transfers
        while (rsp.bvalid !== 1'b1)
            @(posedge clk_i);
    endtask

    task automatic axr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e);
        rq.push_back({e, d});
        req.arvalid <= 1'b1;
        req.araddr  <= a;
        req.rready  <= 1'b1;
        do
            @(posedge clk_i);
        while (rsp.arready !== 1'b1);
        req.arvalid <= 1'b0;
        while (rsp.rvalid !== 1'b1)
            @(posedge clk_i);
    endtask

    // Pipeline settings trail the register words by one clock
    task automatic check_cfg();
        repeat (2) @(posedge clk_i);
        #1;
        for (int k = 0; k < 3; k++)
        begin
            `CHK(cfg.matrix_coeff[0][k], sh[1 + k][12:0])
            `CHK(cfg.matrix_coeff[1][k], sh[5 + k][12:0])
            `CHK(cfg.matrix_offset_term[k], sh[4 * k][13:0])
        end
        `CHK(cfg.stride_active, sh[9][0])
        `CHK(cfg.line_pitch_value, sh[9][0] & sh[10][0])
        `CHK(cfg.in_width, {1'b0, sh[11][12:0]} + 14'h1)
        `CHK(cfg.in_height, {1'b0, sh[11][28:16]} + 14'h1)
        `CHK(cfg.out_width, {1'b0, sh[12][12:0]} + 14'h1)
        `CHK(cfg.out_height, {1'b0, sh[12][28:16]} + 14'h1)
        `CHK(cfg.h_step_integer_part, sh[13][23:16])
        `CHK(cfg.h_step_fraction_part, sh[13][15:0])
        `CHK(cfg.v_step_integer_part, sh[14][23:16])
        `CHK(cfg.v_step_fraction_part, sh[14][15:0])
        `CHK(cfg.h_start_phase, sh[15][19:0])
        `CHK(cfg.v_start_phase, (scan & field) ? sh[17][19:0] : sh[16][19:0])
        @(posedge clk_i);
    endtask

    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial
    begin
        #400000;
        failures++;
        tally_and_finish();
    end

    initial
    begin
        logic [31:0] v;
        req = '0;
        nrst_i = 1'b0;
        field = 1'b0;
        scan = 1'b0;
        failures = 0;
        checks_done = 0;
        void'($urandom(66771));
        foreach (sh[i])
            sh[i] = 32'h0;
        repeat (4) @(posedge clk_i);
        nrst_i <= 1'b1;
        foreach (offs[i])
            axr(offs[i], 32'h0, `RESP_OKAY);
        axr(`OFF_SCAN_CTRL, 32'h0, `RESP_OKAY);
        check_cfg();
        // All ones first for field boundaries, then random words
        for (int r = 0; r < 3; r++)
        begin
            foreach (offs[i])
            begin
                v = (r == 0) ? 32'hFFFF_FFFF : $urandom();
                // Widths stay within the line buffer limit
                if (i == 11 || i == 12)
                    v[12:0] = (r == 0) ? 13'd1365 : v[12:0] % 13'd1366;
                axw(offs[i], v, 4'hF, `RESP_OKAY);
                sh[i] = v & masks[i];
            end
            foreach (offs[i])
                axr(offs[i], sh[i], `RESP_OKAY);
            check_cfg();
        end
        axw(`OFF_IN_SIZE, 32'h1234_5678, 4'b0100, `RESP_OKAY);
        sh[11][23:16] = 8'h34;
        axr(`OFF_IN_SIZE, sh[11], `RESP_OKAY);
        axw(12'h070, 32'hFFFF_FFFF, 4'hF, `RESP_SLVERR);
        axr(12'h070, 32'h0, `RESP_SLVERR);
        axw(`OFF_STATUS, 32'hFFFF_FFFF, 4'hF, `RESP_OKAY);
        for (int m = 0; m < 4; m++)
        begin
            axw(`OFF_STRIDE_EN, {31'h0, m[0]}, 4'hF, `RESP_OKAY);
            sh[9] = {31'h0, m[0]};
            axw(`OFF_SCAN_CTRL, {31'h0, m[1]}, 4'hF, `RESP_OKAY);
            scan = m[1];
            for (int f = 0; f < 2; f++)
            begin
                field <= f[0];
                check_cfg();
                axr(`OFF_STATUS, {30'h0, scan & field, field}, `RESP_OKAY);
                axr(`OFF_SCAN_CTRL, {31'h0, m[1]}, `RESP_OKAY);
            end
        end
        // Second reset in mid-run clears everything again
        nrst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        nrst_i <= 1'b1;
        foreach (sh[i])
            sh[i] = 32'h0;
        scan = 1'b0;
        axr(`OFF_H_PHASE, 32'h0, `RESP_OKAY);
        check_cfg();
        tally_and_finish();
    end
endmodule
`default_nettype wire
